// ==== core/crb_pkg.sv ====
// Constants, register map and state types for the CAN receive buffer register block.
// Assumes a single 125 MHz clock shared with the CAN protocol engine and the AXI4-Lite master.
//
// Contract
// - Identifier high byte shows standard bits 10..3, or extended bits 28..21.
// - Identifier low bits 7..5 show standard bits 2..0, or extended 20..18.
// - Substitute remote flag reads one for extended frames, else control remote copy.
// - Frame-format flag is one for extended frames, zero for standard frames.
// - Identifier low bits 1..0 hold extended bits 17..16; bit 2 reads zero.
// - Extended identifier high register shows extended bits 15..8, bit 15 topmost.
// - Extended identifier low register shows extended bits 7..0, bit 7 topmost.
// - Length register bit 6 is the remote request flag; bit 7 reads zero.
// - Length register bits 5 and 4 are reserved and read zero.
// - Length codes 0..8 give byte count; codes 9..15 are invalid.
// - Each buffer offers eight separately readable payload byte registers.
// - Eight-bit receive error counter follows protocol counting; resets to zero.
// - Receive error count above 127 puts the module into error-passive.
// - Receive error counter alone never causes bus-off.
// - Storing a message sets full; no load into a full buffer.
package crb_pkg;

  localparam int NBUF  = 2;
  localparam int NBYTE = 8;

  // Byte offsets inside one buffer's window, buffer n starts at n * BUF_STRIDE.
  localparam logic [7:0] OFS_IDENT_HIGH  = 8'h00;
  localparam logic [7:0] OFS_IDENT_LOW   = 8'h04;
  localparam logic [7:0] OFS_EXT_HIGH    = 8'h08;
  localparam logic [7:0] OFS_EXT_LOW     = 8'h0c;
  localparam logic [7:0] OFS_LENGTH      = 8'h10;
  localparam logic [7:0] OFS_CONTROL     = 8'h14;
  localparam logic [7:0] OFS_PAYLOAD     = 8'h20;
  localparam logic [7:0] OFS_PAYLOAD_END = 8'h3c;
  localparam logic [7:0] BUF_STRIDE      = 8'h40;
  localparam logic [7:0] BUF_AREA_END    = 8'h80;
  localparam logic [7:0] OFS_ERROR_COUNT = 8'h80;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h84;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h88;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h8c;

  // Control register fields.
  localparam int CTL_FULL     = 7;
  localparam int CTL_MODE_HI  = 6;
  localparam int CTL_MODE_LO  = 5;
  localparam int CTL_RTR_COPY = 3;

  // Identifier low and length register fields.
  localparam int IDL_SRR    = 4;
  localparam int IDL_FORMAT = 3;
  localparam int LEN_RTR    = 6;

  // Interrupt status bits; bits 0 and 1 flag a load into buffer 0 and 1.
  localparam int IRQ_W          = 5;
  localparam int IRQ_OVERRUN    = 2;
  localparam int IRQ_BAD_LENGTH = 3;
  localparam int IRQ_PASSIVE    = 4;

  localparam logic [3:0] DLC_MAX           = 4'h8;
  localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7f;
  localparam logic [7:0] REC_RELOAD        = 8'h77;
  localparam logic [7:0] REC_MAX           = 8'hff;
  localparam logic [7:0] REC_STEP_BIG      = 8'h08;
  localparam logic [7:0] REC_STEP          = 8'h01;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic                 ext;
    logic                 rtr;
    logic [28:0]          id;
    logic [3:0]           dlc;
    logic [NBYTE-1:0][7:0] data;
  } crb_frame_t;

  typedef struct packed {
    crb_frame_t [NBUF-1:0]       frm;
    logic [NBUF-1:0]             full;
    logic [NBUF-1:0][1:0]        mode;
    logic [7:0]                  rec;
    logic                        err_passive;
    logic [IRQ_W-1:0]            irq_stat;
    logic [IRQ_W-1:0]            irq_en;
    logic                        irq;
    logic                        awready;
    logic                        aw_held;
    logic [7:0]                  awaddr;
    logic                        wready;
    logic                        w_held;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } crb_state_t;

endpackage : crb_pkg

// ==== core/crb_rx_buffers.sv ====
// Two CAN receive buffers with their read-only message fields, the receive error
// counter, an interrupt status/enable pair and an AXI4-Lite slave.
// Assumes the protocol engine runs on aclk and presents whole accepted frames.
module crb_rx_buffers (
  input  wire logic                          aclk,            // Module clock.
  input  wire logic                          aresetn,         // Synchronous reset, low.
  input  wire logic [7:0]                    s_axi_awaddr,    // Write address.
  input  wire logic [2:0]                    s_axi_awprot,    // Unused protection.
  input  wire logic                          s_axi_awvalid,   // Write address valid.
  output logic                               s_axi_awready,   // Write address ready.
  input  wire logic [31:0]                   s_axi_wdata,     // Write data.
  input  wire logic [3:0]                    s_axi_wstrb,     // Write strobes.
  input  wire logic                          s_axi_wvalid,    // Write data valid.
  output logic                               s_axi_wready,    // Write data ready.
  output logic [1:0]                         s_axi_bresp,     // Write response.
  output logic                               s_axi_bvalid,    // Write response valid.
  input  wire logic                          s_axi_bready,    // Write response ready.
  input  wire logic [7:0]                    s_axi_araddr,    // Read address.
  input  wire logic [2:0]                    s_axi_arprot,    // Unused protection.
  input  wire logic                          s_axi_arvalid,   // Read address valid.
  output logic                               s_axi_arready,   // Read address ready.
  output logic [31:0]                        s_axi_rdata,     // Read data.
  output logic [1:0]                         s_axi_rresp,     // Read response.
  output logic                               s_axi_rvalid,    // Read data valid.
  input  wire logic                          s_axi_rready,    // Read data ready.
  input  wire logic                          rx_store,        // Accepted frame strobe.
  input  wire logic                          rx_store_buf,    // Target buffer index.
  input  wire logic                          rx_store_ext,    // Frame is extended.
  input  wire logic                          rx_store_rtr,    // Frame is remote request.
  input  wire logic [28:0]                   rx_store_ident,  // Identifier, left aligned.
  input  wire logic [3:0]                    rx_store_dlc,    // Length code.
  input  wire logic [63:0]                   rx_store_data,   // Bytes, byte 0 lowest.
  input  wire logic                          rec_inc_one,     // Receive error, add one.
  input  wire logic                          rec_inc_eight,   // Receive error, add eight.
  input  wire logic                          rec_rx_ok,       // Good frame received.
  output logic [crb_pkg::NBUF-1:0]           buffer_full,     // Buffer full flags.
  output logic [crb_pkg::NBUF-1:0][1:0]      receive_mode,    // Mode bits per buffer.
  output logic                               error_passive,   // Count above limit.
  output logic                               irq              // Level interrupt.
);
  import crb_pkg::*;

  crb_state_t s;
  crb_state_t next_s;

  // Returns {mapped, read value} for a byte address.
  function automatic logic [32:0] rd_word(input crb_state_t st, input logic [7:0] a);
    logic [7:0]  v;
    logic        hit;
    logic        bi;
    logic [7:0]  ofs;
    logic [2:0]  m;
    crb_frame_t  f;
    v   = 8'h00;
    hit = 1'b1;
    bi  = (a >= BUF_STRIDE);
    ofs = bi ? a - BUF_STRIDE : a;
    m   = 3'((ofs - OFS_PAYLOAD) >> 2);
    f   = st.frm[bi];
    if (a[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (a < BUF_AREA_END) begin
      if (ofs >= OFS_PAYLOAD && ofs <= OFS_PAYLOAD_END) begin
        v = f.data[m];
      end else begin
        case (ofs)
          OFS_IDENT_HIGH: v = f.id[28:21];
          OFS_IDENT_LOW: begin
            v[7:5]        = f.id[20:18];
            v[IDL_SRR]    = f.ext | f.rtr;
            v[IDL_FORMAT] = f.ext;
            v[1:0]        = f.id[17:16];
          end
          OFS_EXT_HIGH: v = f.id[15:8];
          OFS_EXT_LOW:  v = f.id[7:0];
          OFS_LENGTH: begin
            v[LEN_RTR] = f.rtr;
            v[3:0]     = f.dlc;
          end
          OFS_CONTROL: begin
            v[CTL_FULL]     = st.full[bi];
            v[CTL_MODE_HI]  = st.mode[bi][1];
            v[CTL_MODE_LO]  = st.mode[bi][0];
            v[CTL_RTR_COPY] = f.rtr;
          end
          default: hit = 1'b0;
        endcase
      end
    end else begin
      case (a)
        OFS_ERROR_COUNT: v = st.rec;
        OFS_IRQ_STATUS:  v = 8'(st.irq_stat);
        OFS_IRQ_CLEAR:   v = 8'h00;
        OFS_IRQ_ENABLE:  v = 8'(st.irq_en);
        default:         hit = 1'b0;
      endcase
    end
    return {hit, 24'h000000, v};
  endfunction : rd_word

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [32:0]      rd;
    logic [32:0]      wr_hit;
    logic             bsel;
    crb_frame_t       nf;
    next_s = s;
    ev     = '0;
    clr    = '0;
    rd     = 33'h000000000;
    wr_hit = 33'h000000000;
    bsel   = 1'b0;
    nf     = '0;

    // Write channel: address and data are taken independently, in either order.
    if (s_axi_awvalid && s.awready) begin
      next_s.awaddr  = s_axi_awaddr;
      next_s.aw_held = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
      next_s.w_held = 1'b1;
      next_s.wready = 1'b0;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      wr_hit         = rd_word(s, s.awaddr);
      bsel           = (s.awaddr >= BUF_STRIDE);
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_hit[32] ? RESP_OKAY : RESP_SLVERR;
      // Only the low byte holds register bits, so only lane 0 writes anything.
      if (s.wstrb[0]) begin
        if (s.awaddr == OFS_CONTROL || s.awaddr == OFS_CONTROL + BUF_STRIDE) begin
          next_s.mode[bsel] = {s.wdata[CTL_MODE_HI], s.wdata[CTL_MODE_LO]};
          // The full flag is clear-only: writing zero releases the buffer.
          if (!s.wdata[CTL_FULL]) begin
            next_s.full[bsel] = 1'b0;
          end
        end
        if (s.awaddr == OFS_IRQ_CLEAR) begin
          clr = s.wdata[IRQ_W-1:0];
        end
        if (s.awaddr == OFS_IRQ_ENABLE) begin
          next_s.irq_en = s.wdata[IRQ_W-1:0];
        end
      end
    end

    // Read channel: data is sampled from the registered state when the address is taken.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s_axi_arvalid && s.arready) begin
      rd             = rd_word(s, s_axi_araddr);
      next_s.rdata   = rd[31:0];
      next_s.rresp   = rd[32] ? RESP_OKAY : RESP_SLVERR;
      next_s.rvalid  = 1'b1;
      next_s.arready = 1'b0;
    end

    // Frame store comes after the software clear so a load into a just-emptied
    // buffer is never undone in the same cycle.
    if (rx_store) begin
      if (s.full[rx_store_buf]) begin
        ev[IRQ_OVERRUN] = 1'b1;
      end else begin
        nf.ext = rx_store_ext;
        nf.rtr = rx_store_rtr;
        nf.id  = rx_store_ident;
        nf.dlc = rx_store_dlc;
        // Bytes past the length code read zero; an invalid code keeps none.
        for (int k = 0; k < NBYTE; k++) begin
          if (rx_store_dlc <= DLC_MAX && 4'(k) < rx_store_dlc) begin
            nf.data[k] = rx_store_data[k*8 +: 8];
          end
        end
        if (rx_store_dlc > DLC_MAX) begin
          ev[IRQ_BAD_LENGTH] = 1'b1;
        end
        next_s.frm[rx_store_buf]  = nf;
        next_s.full[rx_store_buf] = 1'b1;
        ev[32'(rx_store_buf)]     = 1'b1;
      end
    end

    // Receive error counting: eight outranks one, both outrank a good frame.
    if (rec_inc_eight) begin
      next_s.rec = (s.rec > REC_MAX - REC_STEP_BIG) ? REC_MAX : s.rec + REC_STEP_BIG;
    end else if (rec_inc_one) begin
      next_s.rec = (s.rec == REC_MAX) ? REC_MAX : s.rec + REC_STEP;
    end else if (rec_rx_ok) begin
      if (s.rec > REC_PASSIVE_LIMIT) begin
        next_s.rec = REC_RELOAD;
      end else if (s.rec != 8'h00) begin
        next_s.rec = s.rec - REC_STEP;
      end
    end
    // The counter only ever drives error-passive; there is no bus-off path here.
    next_s.err_passive = (next_s.rec > REC_PASSIVE_LIMIT);
    ev[IRQ_PASSIVE]    = next_s.err_passive && !s.err_passive;

    // A new event in the cycle of its clear stays set.
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_en);

    if (!aresetn) begin
      next_s         = '0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign buffer_full   = s.full;
  assign receive_mode  = s.mode;
  assign error_passive = s.err_passive;
  assign irq           = s.irq;

endmodule : crb_rx_buffers

// ==== test/crb_rx_buffers_sva.sv ====
// Port-level assertions for the receive buffer block.
// Assumes one clock domain and the synchronous active-low reset.
module crb_rx_buffers_sva (
  input wire logic        aclk,          // Clock.
  input wire logic        aresetn,       // Reset, low.
  input wire logic        s_axi_awvalid, // Write address valid.
  input wire logic        s_axi_awready, // Write address ready.
  input wire logic        s_axi_wvalid,  // Write data valid.
  input wire logic        s_axi_wready,  // Write data ready.
  input wire logic        s_axi_bvalid,  // Response valid.
  input wire logic        s_axi_bready,  // Response ready.
  input wire logic        s_axi_arvalid, // Read address valid.
  input wire logic        s_axi_arready, // Read address ready.
  input wire logic        s_axi_rvalid,  // Read data valid.
  input wire logic [31:0] s_axi_rdata,   // Read data.
  input wire logic        rx_store,      // Frame strobe.
  input wire logic        rx_store_buf,  // Target buffer.
  input wire logic        rec_inc_one,   // Error, add one.
  input wire logic        rec_inc_eight, // Error, add eight.
  input wire logic [1:0]  buffer_full,   // Full flags.
  input wire logic        error_passive  // Passive state.
);
  import crb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready stayed high");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte");
  a_store_full: assert property (rx_store && !buffer_full[rx_store_buf] |=>
    buffer_full[$past(rx_store_buf)])
    else $error("full flag not set on store");
  a_passive_cause: assert property ($rose(error_passive) |->
    $past(rec_inc_one) || $past(rec_inc_eight)) else $error("passive without error");
  cover property (rx_store && buffer_full[rx_store_buf]);
  cover property ($rose(error_passive));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : crb_rx_buffers_sva

bind crb_rx_buffers crb_rx_buffers_sva crb_rx_buffers_sva_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .rx_store(rx_store), .rx_store_buf(rx_store_buf), .rec_inc_one(rec_inc_one),
  .rec_inc_eight(rec_inc_eight), .buffer_full(buffer_full), .error_passive(error_passive));

// ==== test/crb_engine_model.sv ====
// Behavioural CAN protocol engine that hands accepted frames and error events over.
// Assumes it shares aclk with the block; it answers after a chosen gap.
module crb_engine_model (
  input  wire logic           aclk, // Clock.
  output crb_pkg::crb_frame_t frm,  // Frame lines.
  output logic                st,   // Store strobe.
  output logic                sb,   // Target buffer.
  output logic [2:0]          rec   // Add one, add eight, good frame.
);
  timeunit 1ns;
  timeprecision 1ps;
  import crb_pkg::*;
  initial begin
    frm = '0;
    st  = 1'b0;
    sb  = 1'b0;
    rec = 3'h0;
  end
  task automatic send(input logic b, input crb_frame_t f, input int gap);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    st  <= 1'b1;
    sb  <= b;
    frm <= f;
    @(posedge aclk);
    // Lines flip after the strobe so a late capture cannot look right by luck.
    st  <= 1'b0;
    sb  <= ~b;
    frm <= ~f;
  endtask : send
  task automatic pulse(input int k, input int gap);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    rec <= 3'(1 << k);
    @(posedge aclk);
    rec <= 3'h0;
  endtask : pulse
endmodule : crb_engine_model

// ==== test/test_can_receive_buffer_fields.sv ====
// Self-checking bench for the receive buffer block against a bench model.
// Assumes the engine model on the store side and this bench as AXI master.
module test_can_receive_buffer_fields;
  timeunit 1ns;
  timeprecision 1ps;
  import crb_pkg::*;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic [7:0]      awaddr = 8'h00;
  logic [7:0]      araddr = 8'h00;
  logic [31:0]     wdata = 32'h0;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic            rready = 1'b0;
  logic            awready, wready, bvalid, arready, rvalid, st, sb, passive, irq;
  logic [1:0]      bresp, rresp, full;
  logic [31:0]     rdata;
  logic [2:0]      rec;
  logic [1:0][1:0] rmode;
  crb_frame_t      frm;
  crb_frame_t      m_f [2];
  int              m_rec, n_mismatch, total_checks;
  always #4 aclk = ~aclk;
  crb_engine_model crb_engine_model_i (.aclk(aclk), .frm(frm), .st(st), .sb(sb), .rec(rec));
  crb_rx_buffers crb_rx_buffers_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_store(st), .rx_store_buf(sb),
    .rx_store_ext(frm.ext), .rx_store_rtr(frm.rtr), .rx_store_ident(frm.id),
    .rx_store_dlc(frm.dlc), .rx_store_data(frm.data), .rec_inc_one(rec[0]),
    .rec_inc_eight(rec[1]), .rec_rx_ok(rec[2]), .buffer_full(full), .receive_mode(rmode),
    .error_passive(passive), .irq(irq));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bound(input int k);
    if (k == 40) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : bound
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bound(k);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int   k;
    logic tk;
    @(posedge aclk);
    tk = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (tk && rvalid) break;
      if (!tk && arready) begin
        tk = 1'b1;
        arvalid <= 1'b0;
      end
    end
    bound(k);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask : rd
  function automatic logic [31:0] exp_reg(input int b, input int o);
    crb_frame_t f;
    int         m;
    f = m_f[b];
    m = (o - 32) / 4;
    case (o)
      0:  return {24'h0, f.id[28:21]};
      4:  return {24'h0, f.id[20:18], f.ext | f.rtr, f.ext, 1'b0, f.id[17:16]};
      8:  return {24'h0, f.id[15:8]};
      12: return {24'h0, f.id[7:0]};
      16: return {25'h0, f.rtr, 2'b00, f.dlc};
      default: return (f.dlc > DLC_MAX || m >= f.dlc) ? 32'h0 : {24'h0, f.data[m]};
    endcase
  endfunction : exp_reg
  initial begin
    crb_frame_t f;
    logic [1:0] md;
    int         b, k;
    void'($urandom(24035));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_ERROR_COUNT, 32'h0, RESP_OKAY);
    wr(OFS_IRQ_ENABLE, 8'h1f, RESP_OKAY);
    for (int n = 0; n < 16; n++) begin
      b = n % 2;
      f.ext = n[1];
      f.rtr = 1'($urandom);
      f.id = f.ext ? 29'($urandom) : {11'($urandom), 18'h0};
      f.dlc = 4'(n);
      f.data = {$urandom, $urandom};
      m_f[b] = f;
      crb_engine_model_i.send(1'(b), f, n % 3);
      for (int o = 0; o < 64; o += 4) begin
        if (o < 20 || o >= 32) rd(8'(64 * b + o), exp_reg(b, o), RESP_OKAY);
      end
      chk(32'(full[b]), 32'h1);
      crb_engine_model_i.send(1'(b), ~f, 0);
      rd(8'(64 * b), exp_reg(b, 0), RESP_OKAY);
      rd(8'(64 * b + 16), exp_reg(b, 16), RESP_OKAY);
      rd(OFS_IRQ_STATUS, 32'((1 << b) | 4 | (f.dlc > DLC_MAX ? 8 : 0)), RESP_OKAY);
      chk(32'(irq), 32'h1);
      md = 2'(n >> 2);
      wr(8'(64 * b + 20), {1'b0, md, 5'h0}, RESP_OKAY);
      wr(OFS_IRQ_CLEAR, 8'h1f, RESP_OKAY);
      rd(8'(64 * b + 20), {25'h0, md, 1'b0, f.rtr, 3'h0}, RESP_OKAY);
      chk({28'h0, rmode[b], full[b], irq}, {28'h0, md, 2'b00});
    end
    wr(8'h00, 8'hff, RESP_OKAY);
    rd(8'h00, exp_reg(0, 0), RESP_OKAY);
    rd(8'hfc, 32'h0, RESP_SLVERR);
    wr(8'h02, 8'h01, RESP_SLVERR);
    wr(OFS_IRQ_ENABLE, 8'h00, RESP_OKAY);
    crb_engine_model_i.send(1'b0, f, 1);
    rd(OFS_IRQ_STATUS, 32'(1 | (f.dlc > DLC_MAX ? 8 : 0)), RESP_OKAY);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_ENABLE, 8'h01, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 32'(1 | (f.dlc > DLC_MAX ? 8 : 0)), RESP_OKAY);
    chk(32'(irq), 32'h1);
    // Sixteen big steps reach 128, one good frame reloads, then the count saturates.
    for (int n = 0; n < 50; n++) begin
      k = n < 16 ? 1 : n == 16 ? 2 : n < 49 ? 1 : 0;
      crb_engine_model_i.pulse(k, int'($urandom % 3));
      m_rec = k == 0 ? m_rec + 1 : k == 1 ? m_rec + 8 : m_rec > 127 ? 119 : m_rec - 1;
      if (m_rec > 255) m_rec = 255;
      if (n == 15 || n == 16 || n == 49) begin
        rd(OFS_ERROR_COUNT, 32'(m_rec), RESP_OKAY);
        chk(32'(passive), 32'(m_rec > 127));
      end
    end
    give_verdict();
  end
endmodule : test_can_receive_buffer_fields
